//--- rtl/cgs_pkg.sv
/*
  Constants for the clock generator configuration block: serial slave
  address, command layout, register offsets, field positions and values
  after reset. Assumes a single 10 MHz system clock domain.
*/
package cgs_pkg;

  // ********************************************************************
  // Serial slave
  // ********************************************************************
  localparam logic [6:0] SLAVE_ADDR   = 7'h69;  // Address byte 8'hd2
  localparam int         CMD_SEL_BIT  = 7;      // 1 single, 0 block
  localparam logic [7:0] BLOCK_COUNT  = 8'h0f;  // Block read count
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;  // Bits per byte

  // ********************************************************************
  // Register offsets
  // ********************************************************************
  localparam logic [6:0] OFS_SPREAD_STRAP = 7'h00;  // Spread and straps
  localparam logic [6:0] OFS_OUT_ENABLE   = 7'h01;  // Output enables

  // ********************************************************************
  // Byte 0 fields
  // ********************************************************************
  localparam int         B0_SPREAD   = 5;     // Spread enable
  localparam int         B0_STORAGE  = 4;     // Latched storage select
  localparam logic       SPREAD_RST  = 1'b0;  // Spread off at power-up

  // ********************************************************************
  // Byte 1 fields
  // ********************************************************************
  localparam int         B1_DISPLAY  = 7;     // Display output enable
  localparam int         B1_SRC1     = 3;     // Lowest enable bit
  localparam int         B1_RSV_HI   = 2;     // Reserved, reads one
  localparam int         B1_WOL      = 1;     // Wake keepalive
  localparam logic [4:0] OE_RST      = 5'h1f; // Enables on at power-up
  localparam logic       WOL_RST     = 1'b1;  // Keepalive on
  localparam logic       RSV_HI_VAL  = 1'b1;  // Reserved power-up value

endpackage

//--- rtl/cgs_config.sv
/*
  Configuration and control logic of a multi-output clock generator:
  strap capture on power-good (one-shot outside test mode), wake-on-LAN reference control and
  a byte/block serial slave for control bytes 0 and 1.
  Assumes every pin input is asynchronous to clk_i and that the serial
  clock is much slower than clk_i (it is sampled, not used as a clock).
*/
`timescale 1ns/1ps

module cgs_config (
  // Clock, reset, enable
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       clk_en_i,
  // Serial link pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n_o,
  // Straps and supplies
  input  wire logic       power_good_latch_input_i,
  input  wire logic [2:0] frequency_select_strap_i,
  input  wire logic       storage_rate_select_i,
  input  wire logic       test_mode_i,
  input  wire logic       suspend_supply_i,
  input  wire logic       main_supply_i,
  input  wire logic       wake_stop_pin_n_i,
  // Frequency and output control
  output logic            strap_done_o,
  output logic [1:0]      cpu_rate_sel_o,
  output logic            storage_100m_o,
  output logic            spread_en_o,
  output logic [4:0]      out_en_o,
  output logic            ref25_run_o,
  output logic            xtal_run_o,
  output logic            power_down_o
);
  import cgs_pkg::*;

  // Slave states, Gray coded along the write path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ACK  = 3'h3,
    ST_RX   = 3'h2,
    ST_TX   = 3'h6,
    ST_HACK = 3'h7
  } cgs_state_e;

  // ********************************************************************
  // Input synchronisers
  // ********************************************************************
  logic [10:0] sync1_q;   // First stage, read only by second
  logic [10:0] sync2_q;   // Second stage, safe to use
  logic [1:0]  link3_q;   // Previous scl/sda for edge detection

  // Two flops on every pin; link and wake pins reset to idle high
  // so no false serial edge or stop follows reset
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_q <= 11'h680;
      sync2_q <= 11'h680;
      link3_q <= 2'h3;
    end else if (clk_en_i) begin
      sync1_q <= {scl_i, sda_i, test_mode_i, wake_stop_pin_n_i,
                  main_supply_i, suspend_supply_i,
                  power_good_latch_input_i, storage_rate_select_i,
                  frequency_select_strap_i};
      sync2_q <= sync1_q;
      link3_q <= sync2_q[10:9];
    end
  end

  logic scl_s;          // Synchronised serial clock
  logic sda_s;          // Synchronised serial data
  logic test_s;         // Test mode
  logic wake_n_s;       // Wake stop pin, active low
  logic main_s;         // Main supply present
  logic susp_s;         // Suspend supply present
  logic pg_s;           // Power-good
  logic [3:0] strap_s;  // Storage select and frequency selects
  assign {scl_s, sda_s, test_s, wake_n_s, main_s, susp_s, pg_s} =
         sync2_q[10:4];
  assign strap_s = sync2_q[3:0];

  logic scl_rise;   // Serial clock rising
  logic scl_fall;   // Serial clock falling
  logic start_det;  // Start or repeated start
  logic stop_det;   // Stop
  assign scl_rise  = scl_s & ~link3_q[1];
  assign scl_fall  = ~scl_s & link3_q[1];
  assign start_det = scl_s & link3_q[1] & link3_q[0] & ~sda_s;
  assign stop_det  = scl_s & link3_q[1] & ~link3_q[0] & sda_s;

  // ********************************************************************
  // Strap capture
  // ********************************************************************
  logic       done_q;    // Straps captured
  logic [3:0] strap_q;   // Latched {storage, fs2, fs1, fs0}

  // One-shot capture; test mode lets every high sample recapture
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      done_q  <= 1'b0;
      strap_q <= 4'h0;
    end else if (clk_en_i && pg_s && (!done_q || test_s)) begin
      done_q  <= 1'b1;
      strap_q <= strap_s;
    end
  end

  // ********************************************************************
  // Control registers
  // ********************************************************************
  logic       spread_q;  // Spread enable
  logic [4:0] oe_q;      // Output enables, display down to SRC1
  logic       wol_q;     // Wake keepalive
  logic       wr_fire;   // Data byte write strobe
  logic [6:0] ptr_q;     // Register pointer
  logic [7:0] sh_q;      // Received byte

  // Power-up defaults; reserved bits have no storage
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      spread_q <= SPREAD_RST;
      oe_q     <= OE_RST;
      wol_q    <= WOL_RST;
    end else if (clk_en_i && wr_fire) begin
      case (ptr_q)
        OFS_SPREAD_STRAP: begin
          spread_q <= sh_q[B0_SPREAD];
        end
        OFS_OUT_ENABLE: begin
          oe_q  <= sh_q[B1_DISPLAY:B1_SRC1];
          wol_q <= sh_q[B1_WOL];
        end
        default: begin
          // Bytes outside this block are write-ignored
        end
      endcase
    end
  end

  // Read image of a register; reserved bits at power-up values
  function automatic logic [7:0] rd_byte(input logic [6:0] ofs,
                                         input logic       spr,
                                         input logic [3:0] stp,
                                         input logic [4:0] oe,
                                         input logic       wol);
    logic [7:0] v;
    v = 8'h00;
    case (ofs)
      OFS_SPREAD_STRAP: v = {2'h0, spr, stp[3], 1'b0, stp[2:0]};
      OFS_OUT_ENABLE:   v = {oe, RSV_HI_VAL, wol, 1'b0};
      default:          v = 8'h00;
    endcase
    return v;
  endfunction

  // ********************************************************************
  // Serial slave
  // ********************************************************************
  cgs_state_e st_q;     // Slave state
  logic [3:0] cnt_q;    // Bit counter
  logic [1:0] byte_q;   // Bytes received after address, saturating
  logic       blk_q;    // Block access selected
  logic       rd_q;     // Read direction
  logic       first_q;  // Next transmit byte is the block count
  logic       nack_q;   // Host answered not-acknowledge
  logic [7:0] tx_q;     // Transmit shifter
  logic       byte_end; // Eighth bit seen on a falling edge
  logic       is_data;  // Received byte is a register data byte

  assign byte_end = scl_fall && (cnt_q == BITS_PER_BYTE);
  assign is_data  = (byte_q != 2'h0) && !(blk_q && byte_q == 2'h1);
  assign wr_fire  = (st_q == ST_RX) && byte_end && is_data;

  // Next transmit byte: count first in block mode, then data
  logic [7:0] tx_next;
  assign tx_next = first_q ? BLOCK_COUNT :
                   rd_byte(ptr_q, spread_q, strap_q, oe_q, wol_q);

  // Protocol sequencing
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_q    <= ST_IDLE;
      cnt_q   <= 4'h0;
      byte_q  <= 2'h0;
      blk_q   <= 1'b0;
      rd_q    <= 1'b0;
      first_q <= 1'b0;
      nack_q  <= 1'b0;
      tx_q    <= 8'h00;
      sh_q    <= 8'h00;
      ptr_q   <= 7'h00;
    end else if (clk_en_i) begin
      if (start_det) begin
        // Start or repeated start keeps command context
        st_q  <= ST_ADDR;
        cnt_q <= 4'h0;
      end else if (stop_det) begin
        st_q <= ST_IDLE;
      end else begin
        case (st_q)
          ST_ADDR, ST_RX: begin
            if (scl_rise) begin
              sh_q  <= {sh_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'h1;
            end else if (byte_end && st_q == ST_ADDR) begin
              if (sh_q[7:1] == SLAVE_ADDR) begin
                st_q    <= ST_ACK;
                rd_q    <= sh_q[0];
                first_q <= blk_q;
                if (!sh_q[0]) begin
                  byte_q <= 2'h0;
                end
              end else begin
                st_q <= ST_IDLE;
              end
            end else if (byte_end) begin
              st_q <= ST_ACK;
              if (byte_q == 2'h0) begin
                blk_q <= ~sh_q[CMD_SEL_BIT];
                ptr_q <= sh_q[CMD_SEL_BIT] ? sh_q[6:0] : 7'h00;
              end else if (is_data) begin
                ptr_q <= ptr_q + 7'h01;
              end
              if (byte_q != 2'h2) begin
                byte_q <= byte_q + 2'h1;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              cnt_q <= 4'h0;
              if (rd_q) begin
                st_q    <= ST_TX;
                tx_q    <= tx_next;
                first_q <= 1'b0;
                if (!first_q) begin
                  ptr_q <= ptr_q + 7'h01;
                end
              end else begin
                st_q <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              tx_q  <= {tx_q[6:0], 1'b0};
              cnt_q <= cnt_q + 4'h1;
              if (cnt_q == BITS_PER_BYTE - 4'h1) begin
                st_q <= ST_HACK;
              end
            end
          end
          ST_HACK: begin
            if (scl_rise) begin
              nack_q <= sda_s;
            end else if (scl_fall) begin
              cnt_q <= 4'h0;
              if (nack_q) begin
                st_q <= ST_IDLE;
              end else begin
                st_q    <= ST_TX;
                tx_q    <= tx_next;
                first_q <= 1'b0;
                if (!first_q) begin
                  ptr_q <= ptr_q + 7'h01;
                end
              end
            end
          end
          default: begin
            st_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Open-drain data: enable low pulls the line low
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sda_o      <= 1'b1;
      sda_oe_n_o <= 1'b1;
    end else if (clk_en_i) begin
      sda_o <= 1'b0;
      if (st_q == ST_ACK) begin
        sda_oe_n_o <= 1'b0;
      end else if (st_q == ST_TX) begin
        sda_oe_n_o <= tx_q[7];
      end else begin
        sda_oe_n_o <= 1'b1;
      end
    end
  end

  // ********************************************************************
  // Output control
  // ********************************************************************
  // Registered outputs; one cycle behind their sources
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      strap_done_o   <= 1'b0;
      cpu_rate_sel_o <= 2'h0;
      storage_100m_o <= 1'b1;
      spread_en_o    <= 1'b0;
      out_en_o       <= OE_RST;
      ref25_run_o    <= 1'b0;
      xtal_run_o     <= 1'b0;
      power_down_o   <= 1'b0;
    end else if (clk_en_i) begin
      strap_done_o   <= done_q;
      cpu_rate_sel_o <= strap_q[2:1];
      storage_100m_o <= ~strap_q[3];
      spread_en_o    <= spread_q;
      out_en_o       <= oe_q;
      // Keepalive set runs 25 MHz from suspend alone
      ref25_run_o    <= susp_s & (wol_q | (main_s & wake_n_s));
      xtal_run_o     <= (susp_s | main_s)
                        & (wol_q | (main_s & wake_n_s));
      power_down_o   <= ~wol_q & ~wake_n_s;
    end
  end

  // ********************************************************************
  // Assertions
  // ********************************************************************
  a_strap_capture: assert property (@(posedge clk_i)
    disable iff (reset_i || !clk_en_i)
    (pg_s && !done_q) |=> (done_q && strap_q == $past(strap_s)))
    else $error("straps not captured on power-good");
  a_strap_hold: assert property (@(posedge clk_i)
    disable iff (reset_i || !clk_en_i)
    (done_q && !test_s) |=> $stable(strap_q))
    else $error("straps changed after capture");
  a_cpu_rate_map: assert property (@(posedge clk_i)
    disable iff (reset_i || !clk_en_i)
    ##1 cpu_rate_sel_o == $past(strap_q[2:1]))
    else $error("cpu rate select mismatch");
  a_storage_rate: assert property (@(posedge clk_i)
    disable iff (reset_i || !clk_en_i)
    ##1 storage_100m_o != $past(strap_q[3]))
    else $error("storage rate mismatch");
  a_ref_keepalive: assert property (@(posedge clk_i)
    disable iff (reset_i || !clk_en_i)
    (susp_s && wol_q) |=> ref25_run_o)
    else $error("reference stopped with keepalive set");
  a_wake_powerdown: assert property (@(posedge clk_i)
    disable iff (reset_i || !clk_en_i)
    (!wol_q && !wake_n_s) |=> (power_down_o && !ref25_run_o))
    else $error("wake stop not acting as power-down");
  a_xtal_suspend: assert property (@(posedge clk_i)
    disable iff (reset_i || !clk_en_i)
    (!wol_q && !main_s) |=> !xtal_run_o)
    else $error("crystal runs in suspend without keepalive");
  a_addr_match: assert property (@(posedge clk_i)
    disable iff (reset_i || !clk_en_i)
    (st_q == ST_ADDR && byte_end && !start_det && !stop_det)
      |=> (st_q == ST_ACK) == ($past(sh_q[7:1]) == SLAVE_ADDR))
    else $error("address decode wrong");
  a_cmd_decode: assert property (@(posedge clk_i)
    disable iff (reset_i || !clk_en_i)
    (st_q == ST_RX && byte_end && byte_q == 2'h0 && !start_det
     && !stop_det) |=> (blk_q == !$past(sh_q[7])))
    else $error("command mode decode wrong");
  a_ack_drive: assert property (@(posedge clk_i)
    disable iff (reset_i || !clk_en_i)
    (st_q == ST_ACK) |=> !sda_oe_n_o)
    else $error("acknowledge not driven");
  logic [7:0] b1_img;  // Read image of byte 1
  assign b1_img = rd_byte(OFS_OUT_ENABLE, spread_q, strap_q, oe_q, wol_q);
  a_reserved_image: assert property (@(posedge clk_i)
    disable iff (reset_i)
    b1_img[2:0] == {RSV_HI_VAL, wol_q, 1'b0})
    else $error("reserved bits not at power-up values");

  c_reg_write: cover property (@(posedge clk_i) disable iff (reset_i)
    wr_fire);
  c_block_count: cover property (@(posedge clk_i) disable iff (reset_i)
    st_q == ST_ACK && rd_q && first_q && scl_fall);
  c_host_nack: cover property (@(posedge clk_i) disable iff (reset_i)
    st_q == ST_HACK && nack_q && scl_fall);

endmodule

//--- verification/cgs_host_model.sv
/*
  Host controller model for the two-wire serial link: start, stop,
  byte send and byte receive, paced by falling edges of clk_i.
  Assumes the bench resolves the data line with a pull-up.
*/
`timescale 1ns/1ps
module cgs_host_model (
  // Clock
  input  wire logic clk_i,
  // Serial link
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // ******************************************************************
  // Bit timing
  // ******************************************************************
  int gap = 2;  // Clocks per quarter bit, raise it to answer slowly

  // Idle: clock stands high, data released
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  // Quarter bit, stepped off the sampling edge
  task automatic qtr();
    repeat (gap) @(negedge clk_i);
  endtask

  // Start or repeated start: data falls while clock is high
  task automatic start_bit();
    qtr();
    sda_low_o = 1'b0;
    qtr();
    scl_o = 1'b1;
    qtr();
    sda_low_o = 1'b1;
    qtr();
    scl_o = 1'b0;
  endtask

  // Stop: data rises while clock is high, clock then stands still
  task automatic stop_bit();
    qtr();
    sda_low_o = 1'b1;
    qtr();
    scl_o = 1'b1;
    qtr();
    sda_low_o = 1'b0;
    qtr();
  endtask

  // One bit: data changes only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    qtr();
    sda_low_o = !b;
    qtr();
    scl_o = 1'b1;
    qtr();
    r = sda_i;
    qtr();
    scl_o = 1'b0;
  endtask

  // Byte out, top bit first, then the slave's acknowledge
  task automatic send_byte(input logic [7:0] b, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, nak);
  endtask

  // Byte in; the last one is refused so the slave lets go
  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 0; i < 8; i++) begin
      bit_io(1'b1, r);
      b = {b[6:0], r};
    end
    bit_io(last, r);
  endtask
endmodule

//--- verification/testbench.sv
/*
  Self-checking bench for the clock generator configuration block.
  Assumes cgs_host_model as serial host and a pulled-up data line.
*/
`timescale 1ns/1ps
module testbench;
  import cgs_pkg::*;
  // ******************************************************************
  // Stimulus and wiring
  // ******************************************************************
  logic       clk_i     = 1'b0;
  logic       reset_i   = 1'b1;
  logic       pg        = 1'b0;   // Power-good pin
  logic [2:0] fsel      = 3'h5;   // Straps stable before power-good
  logic       ssel      = 1'b1;   // Storage select strap
  logic       test_mode = 1'b0;
  logic       susp      = 1'b1;   // Suspend supply present
  logic       main_on   = 1'b1;   // Main supplies present
  logic       wake_n    = 1'b1;   // Wake-stop pin
  wire        scl, host_low, sda_o, sda_oe_n, done, st100;
  wire        spread, ref25, xtal, pdown;
  wire  [1:0] cpu_sel;
  wire  [4:0] oe;
  wire  [7:0] stat = {done, cpu_sel, st100, spread, ref25, xtal, pdown};
  // Open drain with pull-up: low if either side pulls
  wire        sda_line = !(host_low || (!sda_oe_n && !sda_o));
  int         err_total = 0;
  int         checks    = 0;
  int         cycles    = 0;

  always #50 clk_i = ~clk_i;

  cgs_config dut_u (
    .clk_i(clk_i), .reset_i(reset_i), .clk_en_i(1'b1),
    .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
    .power_good_latch_input_i(pg), .frequency_select_strap_i(fsel),
    .storage_rate_select_i(ssel), .test_mode_i(test_mode),
    .suspend_supply_i(susp), .main_supply_i(main_on),
    .wake_stop_pin_n_i(wake_n), .strap_done_o(done),
    .cpu_rate_sel_o(cpu_sel), .storage_100m_o(st100),
    .spread_en_o(spread), .out_en_o(oe), .ref25_run_o(ref25),
    .xtal_run_o(xtal), .power_down_o(pdown)
  );

  cgs_host_model host_u (
    .clk_i(clk_i), .sda_i(sda_line), .scl_o(scl), .sda_low_o(host_low)
  );

  // ******************************************************************
  // Tasks
  // ******************************************************************
  task automatic complete_run();
    if (err_total == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Byte out with the expected acknowledge level
  task automatic tx(input logic [7:0] b, input logic nak_exp);
    logic nak;
    host_u.send_byte(b, nak);
    chk("ack", {7'h0, nak_exp}, {7'h0, nak});
  endtask

  task automatic rx(input logic last, input logic [7:0] e, input string nm);
    logic [7:0] v;
    host_u.recv_byte(last, v);
    chk(nm, e, v);
  endtask

  task automatic wr(input logic [6:0] ofs, input logic [7:0] v);
    host_u.start_bit();
    tx(8'hd2, 1'b0);
    tx({1'b1, ofs}, 1'b0);
    tx(v, 1'b0);
    host_u.stop_bit();
  endtask

  task automatic rd1(input logic [6:0] ofs, input logic [7:0] e,
                     input string nm);
    host_u.start_bit();
    tx(8'hd2, 1'b0);
    tx({1'b1, ofs}, 1'b0);
    host_u.start_bit();
    tx(8'hd3, 1'b0);
    rx(1'b1, e, nm);
    host_u.stop_bit();
  endtask

  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      err_total++;
      complete_run();
    end
  end

  // ******************************************************************
  // Test sequence
  // ******************************************************************
  initial begin
    tick(4);
    reset_i = 1'b0;
    tick(4);
    chk("out_en", 8'h1f, {3'h0, oe});
    pg = 1'b1;
    tick(6);
    chk("status", 8'hc6, stat);
    fsel = 3'h2;
    ssel = 1'b0;
    pg = 1'b0;
    tick(6);
    pg = 1'b1;
    tick(6);
    chk("status", 8'hc6, stat);
    test_mode = 1'b1;
    tick(6);
    test_mode = 1'b0;
    chk("status", 8'hb6, stat);
    rd1(7'h00, 8'h02, "byte0");
    rd1(7'h01, 8'hfe, "byte1");
    wr(7'h00, 8'hff);
    rd1(7'h00, 8'h22, "byte0");
    chk("status", 8'hbe, stat);
    rd1(7'h05, 8'h00, "unmapped");
    host_u.start_bit();
    tx(8'hd4, 1'b1);
    host_u.stop_bit();
    // Block write with a slow host
    host_u.gap = 4;
    host_u.start_bit();
    tx(8'hd2, 1'b0);
    tx(8'h00, 1'b0);
    tx(8'h02, 1'b0);
    tx(8'h00, 1'b0);
    tx(8'h02, 1'b0);
    host_u.stop_bit();
    host_u.gap = 2;
    chk("out_en", 8'h00, {3'h0, oe});
    chk("status", 8'hb6, stat);
    // Block read, host stops after byte 1
    host_u.start_bit();
    tx(8'hd2, 1'b0);
    tx(8'h00, 1'b0);
    host_u.start_bit();
    tx(8'hd3, 1'b0);
    rx(1'b0, 8'h0f, "count");
    rx(1'b0, 8'h02, "blk0");
    rx(1'b1, 8'h06, "blk1");
    host_u.stop_bit();
    // Keepalive cleared: wake-stop acts as power-down
    wr(7'h01, 8'h00);
    chk("status", 8'hb6, stat);
    wake_n = 1'b0;
    tick(5);
    chk("status", 8'hb1, stat);
    wake_n = 1'b1;
    main_on = 1'b0;
    tick(5);
    chk("status", 8'hb0, stat);
    wr(7'h01, 8'h02);
    chk("status", 8'hb6, stat);
    // Second reset in mid-run
    main_on = 1'b1;
    reset_i = 1'b1;
    tick(4);
    reset_i = 1'b0;
    tick(6);
    chk("out_en", 8'h1f, {3'h0, oe});
    chk("status", 8'hb6, stat);
    rd1(7'h01, 8'hfe, "byte1");
    complete_run();
  end
endmodule
